// ==== core/acr_bank.sv ====
// Control register bank of the stereo codec, loaded by 16-bit control words.
`timescale 1ns/1ns

module acr_bank
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic word_valid_i,
    input wire logic [15:0] word_i,
    output logic word_ready_o,
    output logic [4:0] left_line_gain_o,
    output logic left_line_silence_o,
    output logic [4:0] right_line_gain_o,
    output logic right_line_silence_o,
    output logic [6:0] left_phones_gain_o,
    output logic left_phones_silent_o,
    output logic left_zero_cross_en_o,
    output logic [6:0] right_phones_gain_o,
    output logic right_phones_silent_o,
    output logic right_zero_cross_en_o,
    output logic mic_level_gain_up_o,
    output logic mic_silence_o,
    output logic adc_source_pick_o,
    output logic line_bypass_o,
    output logic dac_to_output_pick_o,
    output logic mic_feedback_path_o,
    output logic [1:0] mic_feedback_atten_o,
    output logic adc_hpf_off_o,
    output logic [1:0] deemphasis_rate_o,
    output logic dac_soft_silence_o,
    output logic dc_offset_keep_o,
    output logic [8:0] power_down_o,
    output logic [8:0] audio_format_o,
    output logic [8:0] sampling_o,
    output logic interface_active_o,
    output logic ignored_write_o
);

    // ------------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------------

    // Splits a control word into address and data. The address sits above the data,
    // so one fixed split serves every register, and a word is always taken whole.
    function automatic logic [6:0] word_addr(input logic [15:0] w);
        word_addr = w[acr_pkg::ADDR_LSB +: acr_pkg::ADDR_W];
    endfunction : word_addr

    function automatic logic [8:0] word_data(input logic [15:0] w);
        word_data = w[acr_pkg::DATA_W-1:0];
    endfunction : word_data

    // Gains at or below this code mute the headphone amplifier.
    localparam logic [6:0] PHONES_MUTE_TOP = 7'h2F;

    // Keeps the line gain and silence bits; bits 6:5 and the copy bit are not stored.
    function automatic logic [8:0] line_field(input logic [8:0] d);
        line_field = d & acr_pkg::MASK_LINE_INPUT;
    endfunction : line_field

    // Keeps the headphone gain and zero-cross bits; the copy bit is not stored.
    function automatic logic [8:0] phones_field(input logic [8:0] d);
        phones_field = d & acr_pkg::MASK_HEADPHONE_OUT;
    endfunction : phones_field

    // The whole bottom band of gain codes mutes, not only code zero.
    function automatic logic phones_silent(input logic [8:0] w);
        phones_silent = (w[acr_pkg::PHONES_GAIN_MSB:acr_pkg::PHONES_GAIN_LSB] <= PHONES_MUTE_TOP);
    endfunction : phones_silent

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------

    // Address and data of the word offered this cycle.
    logic [6:0] addr;
    logic [8:0] data;

    // One stored data word per register, plus the registered mute flags of the phones.
    logic [8:0] left_line_q, left_line_d;
    logic [8:0] right_line_q, right_line_d;
    logic [8:0] left_phones_q, left_phones_d;
    logic [8:0] right_phones_q, right_phones_d;
    logic [8:0] analog_q, analog_d;
    logic [8:0] digital_q, digital_d;
    logic [8:0] power_q, power_d;
    logic [8:0] format_q, format_d;
    logic [8:0] sampling_q, sampling_d;
    logic [8:0] active_q, active_d;
    logic ignored_q, ignored_d;
    logic left_silent_q, left_silent_d;
    logic right_silent_q, right_silent_d;

    assign addr = word_addr(word_i);
    assign data = word_data(word_i);

    // The bank takes a whole word every cycle, so it never holds the host off.
    // The serial front end that builds the words therefore needs no stall path.
    assign word_ready_o = 1'b1;

    // ------------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------------

    // Copy bits act only on the word that carries them and are not stored, so a later
    // write to one channel never drags the other along. Masking drops bits that hold no field.
    // An address outside the map touches no register and raises only the ignored pulse.
    // All next values except the ignored pulse start from the stored ones, so a missing write leaves state alone.
    always_comb
    begin
        left_line_d = left_line_q;
        right_line_d = right_line_q;
        left_phones_d = left_phones_q;
        right_phones_d = right_phones_q;
        analog_d = analog_q;
        digital_d = digital_q;
        power_d = power_q;
        format_d = format_q;
        sampling_d = sampling_q;
        active_d = active_q;
        ignored_d = 1'b0;
        if (word_valid_i)
        begin
            unique case (addr)
                acr_pkg::ADDR_LEFT_LINE_INPUT:
                begin
                    left_line_d = line_field(data);
                    // A set copy bit loads the right channel from this same word.
                    if (data[acr_pkg::COPY_BIT])
                    begin
                        right_line_d = line_field(data);
                    end
                end
                acr_pkg::ADDR_RIGHT_LINE_INPUT:
                begin
                    right_line_d = line_field(data);
                    // A set copy bit loads the left channel from this same word.
                    if (data[acr_pkg::COPY_BIT])
                    begin
                        left_line_d = line_field(data);
                    end
                end
                acr_pkg::ADDR_LEFT_HEADPHONE_OUT:
                begin
                    left_phones_d = phones_field(data);
                    // Gain and zero-cross enable travel together to the right side.
                    if (data[acr_pkg::COPY_BIT])
                    begin
                        right_phones_d = phones_field(data);
                    end
                end
                acr_pkg::ADDR_RIGHT_HEADPHONE_OUT:
                begin
                    right_phones_d = phones_field(data);
                    // Gain and zero-cross enable travel together to the left side.
                    if (data[acr_pkg::COPY_BIT])
                    begin
                        left_phones_d = phones_field(data);
                    end
                end
                acr_pkg::ADDR_ANALOG_PATH_CONTROL:
                begin
                    analog_d = data & acr_pkg::MASK_ANALOG_PATH;
                end
                acr_pkg::ADDR_DIGITAL_PATH_CONTROL:
                begin
                    digital_d = data & acr_pkg::MASK_DIGITAL_PATH;
                end
                acr_pkg::ADDR_POWER_DOWN_CONTROL:
                begin
                    power_d = data & acr_pkg::MASK_POWER_DOWN;
                end
                acr_pkg::ADDR_AUDIO_INTERFACE_FORMAT:
                begin
                    format_d = data & acr_pkg::MASK_AUDIO_FORMAT;
                end
                acr_pkg::ADDR_SAMPLING_CONTROL:
                begin
                    sampling_d = data & acr_pkg::MASK_SAMPLING;
                end
                acr_pkg::ADDR_INTERFACE_ACTIVATION:
                begin
                    active_d = data & acr_pkg::MASK_ACTIVATION;
                end
                acr_pkg::ADDR_SOFT_RESET:
                begin
                    // Any data value resets; the word is a command, not storage.
                    // Address 15 is defined, so the ignored pulse stays low here.
                    left_line_d = acr_pkg::RST_LINE_INPUT;
                    right_line_d = acr_pkg::RST_LINE_INPUT;
                    left_phones_d = acr_pkg::RST_HEADPHONE_OUT;
                    right_phones_d = acr_pkg::RST_HEADPHONE_OUT;
                    analog_d = acr_pkg::RST_ANALOG_PATH;
                    digital_d = acr_pkg::RST_DIGITAL_PATH;
                    power_d = acr_pkg::RST_POWER_DOWN;
                    format_d = acr_pkg::RST_AUDIO_FORMAT;
                    sampling_d = acr_pkg::RST_SAMPLING;
                    active_d = acr_pkg::RST_ACTIVATION;
                end
                default:
                begin
                    // Addresses 10 to 14 and from 16 up hold no register.
                    ignored_d = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    // Reset values leave the line inputs, the mic and the DAC muted; the phones gains sit above the mute band.
    // The reset is synchronous, so reset_i must stand over at least one rising edge;
    // a word offered in that cycle is lost, which is the price of a plain clocked reset.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            left_line_q <= acr_pkg::RST_LINE_INPUT;
            right_line_q <= acr_pkg::RST_LINE_INPUT;
            left_phones_q <= acr_pkg::RST_HEADPHONE_OUT;
            right_phones_q <= acr_pkg::RST_HEADPHONE_OUT;
            analog_q <= acr_pkg::RST_ANALOG_PATH;
            digital_q <= acr_pkg::RST_DIGITAL_PATH;
            power_q <= acr_pkg::RST_POWER_DOWN;
            format_q <= acr_pkg::RST_AUDIO_FORMAT;
            sampling_q <= acr_pkg::RST_SAMPLING;
            active_q <= acr_pkg::RST_ACTIVATION;
            ignored_q <= 1'b0;
        end
        else
        begin
            left_line_q <= left_line_d;
            right_line_q <= right_line_d;
            left_phones_q <= left_phones_d;
            right_phones_q <= right_phones_d;
            analog_q <= analog_d;
            digital_q <= digital_d;
            power_q <= power_d;
            format_q <= format_d;
            sampling_q <= sampling_d;
            active_q <= active_d;
            ignored_q <= ignored_d;
        end
    end

    // ------------------------------------------------------------------
    // Headphone mute flags
    // ------------------------------------------------------------------

    // The flags are decoded from the next gains and registered beside them,
    // so a flag and the gain it describes always change on the same edge.
    // This costs two flip-flops but keeps every data output off a compare.
    always_comb
    begin
        left_silent_d = phones_silent(left_phones_d);
        right_silent_d = phones_silent(right_phones_d);
    end

    // Reset gains sit above the mute band, so both flags start low.
    // The reset value is taken through the same decode, so the two cannot drift apart.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            left_silent_q <= phones_silent(acr_pkg::RST_HEADPHONE_OUT);
            right_silent_q <= phones_silent(acr_pkg::RST_HEADPHONE_OUT);
        end
        else
        begin
            left_silent_q <= left_silent_d;
            right_silent_q <= right_silent_d;
        end
    end

    // ------------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------------

    // Line input controls, straight from the stored words.
    // Bits 6:5 of these words never hold anything, so they are not looked at.
    assign left_line_gain_o = left_line_q[acr_pkg::LINE_GAIN_MSB:acr_pkg::LINE_GAIN_LSB];
    assign left_line_silence_o = left_line_q[acr_pkg::SILENCE_BIT];
    assign right_line_gain_o = right_line_q[acr_pkg::LINE_GAIN_MSB:acr_pkg::LINE_GAIN_LSB];
    assign right_line_silence_o = right_line_q[acr_pkg::SILENCE_BIT];

    // Headphone controls; the mute flags come registered so the analog side needs no compare.
    // Zero-cross enables only ask the analog side to wait; the gain word itself changes at once.
    assign left_phones_gain_o = left_phones_q[acr_pkg::PHONES_GAIN_MSB:acr_pkg::PHONES_GAIN_LSB];
    assign left_phones_silent_o = left_silent_q;
    assign left_zero_cross_en_o = left_phones_q[acr_pkg::ZERO_CROSS_BIT];
    assign right_phones_gain_o = right_phones_q[acr_pkg::PHONES_GAIN_MSB:acr_pkg::PHONES_GAIN_LSB];
    assign right_phones_silent_o = right_silent_q;
    assign right_zero_cross_en_o = right_phones_q[acr_pkg::ZERO_CROSS_BIT];

    // Analog path switches.
    // Each switch is a plain stored bit; the analog side owns any click suppression.
    assign mic_level_gain_up_o = analog_q[acr_pkg::MIC_GAIN_UP_BIT];
    assign mic_silence_o = analog_q[acr_pkg::MIC_SILENCE_BIT];
    assign adc_source_pick_o = analog_q[acr_pkg::ADC_SOURCE_BIT];
    assign line_bypass_o = analog_q[acr_pkg::BYPASS_BIT];
    assign dac_to_output_pick_o = analog_q[acr_pkg::DAC_PICK_BIT];
    assign mic_feedback_path_o = analog_q[acr_pkg::FEEDBACK_BIT];
    assign mic_feedback_atten_o = analog_q[acr_pkg::FEEDBACK_ATTEN_MSB:acr_pkg::FEEDBACK_ATTEN_LSB];

    // Digital path controls; the filter bit is passed with its inverted sense intact.
    // A low filter bit therefore means the filter runs, which is the reset state.
    assign adc_hpf_off_o = digital_q[acr_pkg::HPF_OFF_BIT];
    assign deemphasis_rate_o = digital_q[acr_pkg::DEEMPH_MSB:acr_pkg::DEEMPH_LSB];
    assign dac_soft_silence_o = digital_q[acr_pkg::DAC_SILENCE_BIT];
    assign dc_offset_keep_o = digital_q[acr_pkg::DC_KEEP_BIT];

    // Whole words of the power-down, format and sampling registers; activation gives only its active bit.
    // Their fields are decoded by the blocks that use them, not by the bank.
    assign power_down_o = power_q;
    assign audio_format_o = format_q;
    assign sampling_o = sampling_q;
    assign interface_active_o = active_q[acr_pkg::ACTIVE_BIT];
    assign ignored_write_o = ignored_q;

endmodule : acr_bank

// ==== pkg/acr_pkg.sv ====
// Package of addresses, field positions and reset values for the codec control register bank.
package acr_pkg;

    // ------------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam int ADDR_LSB = 9;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_LEFT_LINE_INPUT = 7'h00;
    localparam logic [6:0] ADDR_RIGHT_LINE_INPUT = 7'h01;
    localparam logic [6:0] ADDR_LEFT_HEADPHONE_OUT = 7'h02;
    localparam logic [6:0] ADDR_RIGHT_HEADPHONE_OUT = 7'h03;
    localparam logic [6:0] ADDR_ANALOG_PATH_CONTROL = 7'h04;
    localparam logic [6:0] ADDR_DIGITAL_PATH_CONTROL = 7'h05;
    localparam logic [6:0] ADDR_POWER_DOWN_CONTROL = 7'h06;
    localparam logic [6:0] ADDR_AUDIO_INTERFACE_FORMAT = 7'h07;
    localparam logic [6:0] ADDR_SAMPLING_CONTROL = 7'h08;
    localparam logic [6:0] ADDR_INTERFACE_ACTIVATION = 7'h09;
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h0F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LINE_GAIN_LSB = 0;
    localparam int LINE_GAIN_MSB = 4;
    localparam int PHONES_GAIN_LSB = 0;
    localparam int PHONES_GAIN_MSB = 6;
    localparam int SILENCE_BIT = 7;
    localparam int ZERO_CROSS_BIT = 7;
    localparam int COPY_BIT = 8;
    localparam int MIC_GAIN_UP_BIT = 0;
    localparam int MIC_SILENCE_BIT = 1;
    localparam int ADC_SOURCE_BIT = 2;
    localparam int BYPASS_BIT = 3;
    localparam int DAC_PICK_BIT = 4;
    localparam int FEEDBACK_BIT = 5;
    localparam int FEEDBACK_ATTEN_LSB = 6;
    localparam int FEEDBACK_ATTEN_MSB = 7;
    localparam int HPF_OFF_BIT = 0;
    localparam int DEEMPH_LSB = 1;
    localparam int DEEMPH_MSB = 2;
    localparam int DAC_SILENCE_BIT = 3;
    localparam int DC_KEEP_BIT = 4;
    localparam int FORMAT_LSB = 0;
    localparam int FORMAT_MSB = 1;
    localparam int ACTIVE_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values, whole 9-bit data words
    // ------------------------------------------------------------------
    localparam logic [8:0] RST_LINE_INPUT = 9'h097;
    localparam logic [8:0] RST_HEADPHONE_OUT = 9'h079;
    localparam logic [8:0] RST_ANALOG_PATH = 9'h00A;
    localparam logic [8:0] RST_DIGITAL_PATH = 9'h008;
    localparam logic [8:0] RST_POWER_DOWN = 9'h09F;
    localparam logic [8:0] RST_AUDIO_FORMAT = 9'h00A;
    localparam logic [8:0] RST_SAMPLING = 9'h000;
    localparam logic [8:0] RST_ACTIVATION = 9'h000;

    // Writable bits of each register; unlisted bits hold zero.
    localparam logic [8:0] MASK_LINE_INPUT = 9'h09F;
    localparam logic [8:0] MASK_HEADPHONE_OUT = 9'h0FF;
    localparam logic [8:0] MASK_ANALOG_PATH = 9'h0FF;
    localparam logic [8:0] MASK_DIGITAL_PATH = 9'h01F;
    localparam logic [8:0] MASK_POWER_DOWN = 9'h0FF;
    localparam logic [8:0] MASK_AUDIO_FORMAT = 9'h0FF;
    localparam logic [8:0] MASK_SAMPLING = 9'h0FF;
    localparam logic [8:0] MASK_ACTIVATION = 9'h001;

endpackage : acr_pkg

// ==== verif/acr_bank_assertions.sv ====
// Concurrent checks on the ports of the codec control register bank.
`timescale 1ns/1ns

module acr_bank_checker
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic word_valid_i,
    input wire logic [15:0] word_i,
    input wire logic word_ready_o,
    input wire logic [4:0] left_line_gain_o,
    input wire logic left_line_silence_o,
    input wire logic [4:0] right_line_gain_o,
    input wire logic right_line_silence_o,
    input wire logic [6:0] left_phones_gain_o,
    input wire logic left_phones_silent_o,
    input wire logic [6:0] right_phones_gain_o,
    input wire logic dac_soft_silence_o,
    input wire logic interface_active_o,
    input wire logic ignored_write_o
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Only addresses 0 to 9 and 15 hold registers.
    function automatic logic undef_addr(input logic [6:0] a);
        return (a > 7'h09) && (a != 7'h0F);
    endfunction : undef_addr

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_ready; word_ready_o == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("bank refused a word");
    property p_lcopy; word_valid_i && word_i[15:9] == 7'h00 && word_i[8] |=> left_line_gain_o == $past(word_i[4:0])
        && right_line_gain_o == $past(word_i[4:0]) && right_line_silence_o == $past(word_i[7]); endproperty
    a_lcopy: assert property (p_lcopy) else $error("left line copy wrong");
    property p_lonly; word_valid_i && word_i[15:9] == 7'h00 && !word_i[8] |=> $stable(right_line_gain_o)
        && $stable(right_line_silence_o) && left_line_silence_o == $past(word_i[7]); endproperty
    a_lonly: assert property (p_lonly) else $error("right line changed without copy");
    property p_rcopy; word_valid_i && word_i[15:9] == 7'h01 && word_i[8] |=> left_line_gain_o == $past(word_i[4:0])
        && left_line_silence_o == $past(word_i[7]); endproperty
    a_rcopy: assert property (p_rcopy) else $error("right line copy wrong");
    property p_silent; left_phones_silent_o == (left_phones_gain_o[6:4] < 3'h3); endproperty
    a_silent: assert property (p_silent) else $error("phones silence decode wrong");
    property p_hcopy; word_valid_i && word_i[15:9] == 7'h02 && word_i[8]
        |=> right_phones_gain_o == $past(word_i[6:0]); endproperty
    a_hcopy: assert property (p_hcopy) else $error("phones copy wrong");
    property p_soft; word_valid_i && word_i[15:9] == 7'h0F |=> left_line_gain_o == 5'h17 && left_line_silence_o
        && right_phones_gain_o == 7'h79 && dac_soft_silence_o; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed");
    property p_ignore; word_valid_i && undef_addr(word_i[15:9]) |=> ignored_write_o
        && $stable(left_line_gain_o) && $stable(interface_active_o); endproperty
    a_ignore: assert property (p_ignore) else $error("undefined write not ignored");
    property p_pulse; ignored_write_o |-> $past(word_valid_i) && undef_addr($past(word_i[15:9])); endproperty
    a_pulse: assert property (p_pulse) else $error("spurious ignored pulse");

    c_lcopy: cover property (word_valid_i && word_i[15:9] == 7'h00 && word_i[8]);
    c_soft: cover property (word_valid_i && word_i[15:9] == 7'h0F);
    c_ignore: cover property (ignored_write_o);
endmodule : acr_bank_checker

bind acr_bank acr_bank_checker chk (.*);

// ==== verif/acr_host.sv ====
// Host processor model that issues 16-bit control words to the bank.
`timescale 1ns/1ns

module acr_host
(
    input wire logic core_clk_i,
    output logic word_valid_o,
    output logic [15:0] word_o
);
    // Host starts idle.
    initial
    begin
        word_valid_o = 1'b0;
        word_o = 16'h0000;
    end

    // Offers one word for one rising edge; callers enter at a falling edge.
    task automatic write(input logic [6:0] addr, input logic [8:0] data);
        word_o = {addr, data};
        word_valid_o = 1'b1;
        @(negedge core_clk_i);
    endtask : write

    // Inverting the bus on release keeps stale data from passing as a match.
    // One idle edge passes before return, so the next call never drives in the same step.
    task automatic idle();
        word_valid_o = 1'b0;
        word_o = ~word_o;
        @(negedge core_clk_i);
    endtask : idle
endmodule : acr_host

// ==== verif/tb.sv ====
// Self-checking testbench for the codec control register bank.
`timescale 1ns/1ns

module tb;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    wire word_valid_i;
    wire [15:0] word_i;
    logic [4:0] left_line_gain_o, right_line_gain_o;
    logic [6:0] left_phones_gain_o, right_phones_gain_o;
    logic [1:0] mic_feedback_atten_o, deemphasis_rate_o;
    logic [8:0] power_down_o, audio_format_o, sampling_o;
    logic word_ready_o, left_line_silence_o, right_line_silence_o, left_phones_silent_o, left_zero_cross_en_o;
    logic right_phones_silent_o, right_zero_cross_en_o, mic_level_gain_up_o, mic_silence_o, adc_source_pick_o;
    logic line_bypass_o, dac_to_output_pick_o, mic_feedback_path_o, adc_hpf_off_o, dac_soft_silence_o;
    logic dc_offset_keep_o, interface_active_o, ignored_write_o;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    acr_host host (.core_clk_i(core_clk_i), .word_valid_o(word_valid_i), .word_o(word_i));
    acr_bank uut (.*);

    // ------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------
    always #2 core_clk_i = ~core_clk_i;

    // The whole run needs under a hundred cycles; a hang is cut off well above that.
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic check_defaults();
        cmp({left_line_silence_o, left_line_gain_o}, 9'h037);
        cmp({right_line_silence_o, right_line_gain_o}, 9'h037);
        cmp({left_phones_silent_o, left_zero_cross_en_o, left_phones_gain_o}, 9'h079);
        cmp({right_phones_silent_o, right_zero_cross_en_o, right_phones_gain_o}, 9'h079);
        cmp({mic_feedback_atten_o, mic_feedback_path_o, dac_to_output_pick_o, line_bypass_o, adc_source_pick_o,
            mic_silence_o, mic_level_gain_up_o}, 9'h00A);
        cmp({dc_offset_keep_o, dac_soft_silence_o, deemphasis_rate_o, adc_hpf_off_o}, 9'h008);
        cmp(power_down_o, 9'h09F);
        cmp(sampling_o, 9'h000);
        cmp(audio_format_o[1:0], 9'h002);
        cmp({ignored_write_o, interface_active_o, word_ready_o}, 9'h001);
    endtask : check_defaults

    // Back-to-back line writes, with and without the copy bit.
    task automatic t_line();
        host.write(7'h00, 9'h11F);
        cmp({right_line_silence_o, right_line_gain_o}, 9'h01F);
        host.write(7'h00, 9'h080);
        cmp({left_line_silence_o, left_line_gain_o}, 9'h020);
        cmp({right_line_silence_o, right_line_gain_o}, 9'h01F);
        host.write(7'h01, 9'h105);
        cmp({left_line_silence_o, left_line_gain_o}, 9'h005);
        host.write(7'h01, 9'h09A);
        cmp({left_line_silence_o, left_line_gain_o}, 9'h005);
        cmp({right_line_silence_o, right_line_gain_o}, 9'h03A);
        host.idle();
    endtask : t_line

    // Phones gain at the silence boundary and both copy directions.
    task automatic t_phones();
        host.write(7'h02, 9'h1FF);
        cmp({right_phones_silent_o, right_zero_cross_en_o, right_phones_gain_o}, 9'h0FF);
        host.write(7'h02, 9'h02F);
        cmp({left_phones_silent_o, left_zero_cross_en_o, left_phones_gain_o}, 9'h12F);
        cmp({right_zero_cross_en_o, right_phones_gain_o}, 9'h0FF);
        host.write(7'h03, 9'h130);
        cmp({left_phones_silent_o, left_zero_cross_en_o, left_phones_gain_o}, 9'h030);
        host.write(7'h03, 9'h0AF);
        cmp({right_phones_silent_o, right_zero_cross_en_o, right_phones_gain_o}, 9'h1AF);
        cmp({left_phones_silent_o, left_zero_cross_en_o, left_phones_gain_o}, 9'h030);
        host.idle();
    endtask : t_phones

    // Every mic_feedback_path attenuation and de-emphasis code, with the single bits toggled.
    task automatic t_paths();
        logic [8:0] d;
        logic [1:0] k;
        for (int i = 0; i < 4; i++)
        begin
            k = 2'(i);
            d = {1'b0, k, (k[0] ? 6'h2A : 6'h15)};
            host.write(7'h04, d);
            cmp({mic_feedback_atten_o, mic_feedback_path_o, dac_to_output_pick_o, line_bypass_o, adc_source_pick_o,
                mic_silence_o, mic_level_gain_up_o}, d);
            d = {4'h0, k[0], ~k[0], k, k[1]};
            host.write(7'h05, d);
            cmp({dc_offset_keep_o, dac_soft_silence_o, deemphasis_rate_o, adc_hpf_off_o}, d);
            host.write(7'h07, {7'h02, k});
            cmp(audio_format_o[1:0], 9'(k));
        end
        host.idle();
    endtask : t_paths

    // Power-down, undefined addresses, then soft reset restores all defaults.
    task automatic t_misc();
        host.write(7'h06, 9'h000);
        cmp(power_down_o, 9'h000);
        host.write(7'h08, 9'h0A5);
        cmp(sampling_o, 9'h0A5);
        host.write(7'h09, 9'h001);
        host.write(7'h0A, 9'h000);
        cmp({ignored_write_o, interface_active_o}, 9'h003);
        host.write(7'h7F, 9'h1FF);
        cmp({ignored_write_o, left_line_silence_o, left_line_gain_o}, 9'h045);
        cmp(power_down_o, 9'h000);
        host.idle();
        @(negedge core_clk_i);
        cmp(ignored_write_o, 9'h000);
        host.write(7'h0F, 9'h000);
        host.idle();
        check_defaults();
    endtask : t_misc

    // A second reset in mid-run, after the bank has been moved off its defaults.
    task automatic t_reset();
        host.write(7'h00, 9'h11F);
        host.write(7'h04, 9'h0FF);
        host.idle();
        reset_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        reset_i = 1'b0;
        check_defaults();
    endtask : t_reset

    // Main sequence: hold reset five cycles, release at a falling edge.
    initial
    begin
        repeat (5) @(negedge core_clk_i);
        reset_i = 1'b0;
        check_defaults();
        t_line();
        t_phones();
        t_paths();
        t_misc();
        t_reset();
        end_of_test();
    end
endmodule : tb
